// [verilog/pmsc_regs.svh]
// register offsets, field positions, reset values and counts for power mode control
// assumes inclusion by the rate divider and the main module only
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH
`define PMSC_ADDR_POWER_CONTROL   8'h87
`define PMSC_ADDR_CLOCK_RATE      8'h8e
`define PMSC_ADDR_EXT_FLAG        8'h91
`define PMSC_ADDR_PROTECT         8'hc7
`define PMSC_ADDR_SUPERVISOR      8'hd8
`define PMSC_ADDR_POWER_MGMT      8'hc4
`define PMSC_BIT_IDLE             0
`define PMSC_BIT_STOP             1
`define PMSC_BIT_BANDGAP          0
`define PMSC_BIT_RING_SEL         1
`define PMSC_BIT_RING_ACT         2
`define PMSC_BIT_STROBE_OFF       2
`define PMSC_BIT_T0_RATE          3
`define PMSC_BIT_T1_RATE          4
`define PMSC_BIT_T2_RATE          5
`define PMSC_BIT_PF_FLAG          4
`define PMSC_BIT_PF_EN            5
`define PMSC_KEY_FIRST            8'haa
`define PMSC_KEY_SECOND           8'h55
`define PMSC_PROT_WINDOW          2'd3
`define PMSC_WAKE_COUNT           17'h10000
`define PMSC_DIV_FAST             4'd4
`define PMSC_DIV_SLOW             4'd12
`define PMSC_PF_VECTOR            16'h0033
`define PMSC_RESET_BYTE           8'h00
`endif

// [verilog/pmsc_pkg.sv]
// types shared by the power mode control files
// assumes the register header is on the include path
package pmsc_pkg;
    typedef enum logic [3:0] {
        PM_RUN  = 4'b0001,
        PM_IDLE = 4'b0010,
        PM_STOP = 4'b0100,
        PM_RING = 4'b1000
    } pmsc_mode_t;
endpackage

// [verilog/pmsc_rate_div.sv]
// one-cycle enable every 4 or 12 clocks for one timer
// assumes the system clock is the crystal clock
`timescale 1ns/10ps
`include "pmsc_regs.svh"
module pmsc_rate_div
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // control
    input  wire logic run_i,
    input  wire logic fast_i,
    // tick
    output logic      tick_o
);
    logic [3:0] cnt_r;
    logic [3:0] lim;

    assign lim = fast_i ? `PMSC_DIV_FAST : `PMSC_DIV_SLOW;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_r  <= 4'h0;
            tick_o <= 1'b0;
        end
        else if (!run_i)
        begin
            tick_o <= 1'b0;
        end
        else if (cnt_r >= lim - 4'h1)
        begin
            cnt_r  <= 4'h0;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_r  <= cnt_r + 4'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

// [verilog/pmsc_power_ctrl.sv]
// power mode, supply supervision and timer rate control
// assumes a core write/read strobe port and synchronous supply monitor levels
`timescale 1ns/10ps
`include "pmsc_regs.svh"
// Functional notes
// R01 - bit 0 write enters idle, clocks run
// R02 - any enabled interrupt or reset ends idle
// R03 - bit 1 write enters stop
// R04 - stop gates all clocks and crystal
// R05 - only external interrupt, reset or R07 supply warning ends stop
// R06 - bandgap kept in stop only when set
// R07 - kept bandgap lets supply events end stop
// R08 - bandgap bit ignored outside stop
// R09 - ring select gives ring clock on wake
// R10 - back to crystal after 65536 clocks
// R11 - ring status shows ring clock source
// R12 - default wake from stop uses crystal
// R13 - strobe off: static except external moves
// R14 - strobe on: toggles at crystal over four
// R15 - timers default to twelve clocks
// R16 - three bits pick timer rate 4/12
// R17 - power-up reset held then 65536 count
// R18 - supply below threshold forces reset
// R19 - enabled warning vectors 0033h, top priority
// R20 - supervisor bit 5 enables warning interrupt
// R21 - warning flag sticky until software clears
// R22 - bandgap writes need AAh 55h window
// R23 - mode bits clear on exit
module pmsc_power_ctrl
    import pmsc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // register port
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    // interrupt, supply and external data move inputs
    input  wire logic        irq_enabled_i,
    input  wire logic        ext_irq_i,
    input  wire logic        below_reset_threshold_i,
    input  wire logic        below_warning_threshold_i,
    input  wire logic        ext_data_move_i,
    // clock and power controls
    output logic             cpu_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             crystal_en_o,
    output logic             ring_en_o,
    output logic             bandgap_en_o,
    output logic             latch_strobe_o,
    output logic [2:0]       timer_tick_o,
    // reset and warning interrupt
    output logic             core_reset_o,
    output logic             pf_irq_o,
    output logic [15:0]      pf_vector_o
);
    pmsc_mode_t  mode_r;
    pmsc_mode_t  mode_nxt;
    logic        idle_req_r;
    logic        stop_req_r;
    logic        bandgap_keep_r;
    logic        ring_sel_r;
    logic        strobe_off_r;
    logic [2:0]  rate_fast_r;
    logic        pf_en_r;
    logic        pf_flag_r;
    logic [16:0] wake_cnt_r;
    logic [16:0] por_cnt_r;
    logic        por_busy_r;
    logic [1:0]  key_state_r;
    logic [1:0]  win_cnt_r;
    logic [1:0]  strobe_div_r;
    logic [2:0]  tick_w;
    logic        pf_wake;
    logic        stop_exit;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = wr_i && (a == target);
    endfunction

    // supply warning may end stop only with bandgap kept on
    assign pf_wake   = bandgap_keep_r && below_warning_threshold_i && pf_en_r;  // [R07]
    assign stop_exit = ext_irq_i || pf_wake;  // [R05] [R07]

    // power-on and brownout reset counter
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            por_cnt_r  <= 17'h0;
            por_busy_r <= 1'b1;
        end
        else if (below_reset_threshold_i)
        begin
            por_cnt_r  <= 17'h0;  // [R18]
            por_busy_r <= 1'b1;
        end
        else if (por_busy_r)
        begin
            if (por_cnt_r == `PMSC_WAKE_COUNT - 17'h1)
                por_busy_r <= 1'b0;  // [R17]
            por_cnt_r <= por_cnt_r + 17'h1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            core_reset_o <= 1'b1;
        else
            core_reset_o <= below_reset_threshold_i || por_busy_r;  // [R17] [R18]
    end

    // timed access window for the bandgap bit
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            key_state_r <= 2'd0;
            win_cnt_r   <= 2'd0;
        end
        else
        begin
            if (win_cnt_r != 2'd0)
                win_cnt_r <= win_cnt_r - 2'd1;
            if (hit(addr_i, `PMSC_ADDR_PROTECT))
            begin
                if (wdata_i == `PMSC_KEY_FIRST)
                    key_state_r <= 2'd1;
                else if (wdata_i == `PMSC_KEY_SECOND && key_state_r == 2'd1)
                begin
                    key_state_r <= 2'd0;
                    win_cnt_r   <= `PMSC_PROT_WINDOW;  // [R22]
                end
                else
                    key_state_r <= 2'd0;
            end
            else if (wr_i)
                key_state_r <= 2'd0;
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            bandgap_keep_r <= 1'b0;  // [R06]
            ring_sel_r     <= 1'b0;  // [R12]
            strobe_off_r   <= 1'b0;  // [R14]
            rate_fast_r    <= 3'b000;  // [R15]
            pf_en_r        <= 1'b0;
        end
        else if (core_reset_o)
        begin
            bandgap_keep_r <= 1'b0;
            ring_sel_r     <= 1'b0;
            strobe_off_r   <= 1'b0;
            rate_fast_r    <= 3'b000;
            pf_en_r        <= 1'b0;
        end
        else
        begin
            if (hit(addr_i, `PMSC_ADDR_EXT_FLAG))
            begin
                ring_sel_r <= wdata_i[`PMSC_BIT_RING_SEL];  // [R09]
                if (win_cnt_r != 2'd0)
                    bandgap_keep_r <= wdata_i[`PMSC_BIT_BANDGAP];  // [R22]
            end
            if (hit(addr_i, `PMSC_ADDR_POWER_MGMT))
                strobe_off_r <= wdata_i[`PMSC_BIT_STROBE_OFF];  // [R13]
            if (hit(addr_i, `PMSC_ADDR_CLOCK_RATE))
                rate_fast_r <= wdata_i[`PMSC_BIT_T2_RATE:`PMSC_BIT_T0_RATE];  // [R16]
            if (hit(addr_i, `PMSC_ADDR_SUPERVISOR))
                pf_en_r <= wdata_i[`PMSC_BIT_PF_EN];  // [R20]
        end
    end

    // sticky warning flag, set wins over clear
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pf_flag_r <= 1'b0;
        else if (below_warning_threshold_i && (mode_r != PM_STOP || bandgap_keep_r))
            pf_flag_r <= 1'b1;  // [R21]
        else if (hit(addr_i, `PMSC_ADDR_SUPERVISOR) && !wdata_i[`PMSC_BIT_PF_FLAG])
            pf_flag_r <= 1'b0;  // [R21]
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pf_irq_o    <= 1'b0;
            pf_vector_o <= 16'h0000;
        end
        else
        begin
            pf_irq_o    <= pf_flag_r && pf_en_r && !core_reset_o;  // [R19]
            pf_vector_o <= `PMSC_PF_VECTOR;  // [R19]
        end
    end

    // mode machine
    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            PM_RUN:
            begin
                if (hit(addr_i, `PMSC_ADDR_POWER_CONTROL) && wdata_i[`PMSC_BIT_STOP])
                    mode_nxt = PM_STOP;  // [R03]
                else if (hit(addr_i, `PMSC_ADDR_POWER_CONTROL) && wdata_i[`PMSC_BIT_IDLE])
                    mode_nxt = PM_IDLE;  // [R01]
            end
            PM_IDLE:
                if (irq_enabled_i || (pf_flag_r && pf_en_r))
                    mode_nxt = PM_RUN;  // [R02]
            PM_STOP:
                if (stop_exit)
                    mode_nxt = ring_sel_r ? PM_RING : PM_RUN;  // [R09] [R12]
            PM_RING:
                if (wake_cnt_r == `PMSC_WAKE_COUNT - 17'h1)
                    mode_nxt = PM_RUN;  // [R10]
                else if (hit(addr_i, `PMSC_ADDR_POWER_CONTROL) && wdata_i[`PMSC_BIT_STOP])
                    mode_nxt = PM_STOP;
            default:
                mode_nxt = PM_RUN;
        endcase
        if (core_reset_o)
            mode_nxt = PM_RUN;  // [R02] [R05]
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            mode_r <= PM_RUN;
        else
            mode_r <= mode_nxt;
    end

    // request bits follow the mode and drop on exit
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
        end
        else
        begin
            idle_req_r <= (mode_nxt == PM_IDLE) && !core_reset_o;  // [R23]
            stop_req_r <= (mode_nxt == PM_STOP) && !core_reset_o;  // [R23]
        end
    end

    // crystal count after ring wake
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            wake_cnt_r <= 17'h0;
        else if (mode_r == PM_RING && mode_nxt == PM_RING)
            wake_cnt_r <= wake_cnt_r + 17'h1;  // [R10]
        else
            wake_cnt_r <= 17'h0;
    end

    // clock and reference enables
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cpu_clk_en_o    <= 1'b0;
            periph_clk_en_o <= 1'b0;
            crystal_en_o    <= 1'b1;
            ring_en_o       <= 1'b0;
            bandgap_en_o    <= 1'b1;
        end
        else
        begin
            cpu_clk_en_o    <= (mode_nxt == PM_RUN || mode_nxt == PM_RING) && !core_reset_o;  // [R01]
            periph_clk_en_o <= mode_nxt != PM_STOP;  // [R01] [R04]
            crystal_en_o    <= mode_nxt != PM_STOP;  // [R04] [R17]
            ring_en_o       <= mode_nxt == PM_RING;  // [R09] [R11]
            bandgap_en_o    <= (mode_nxt != PM_STOP) || bandgap_keep_r;  // [R06] [R08]
        end
    end

    // address latch strobe at crystal over four
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            strobe_div_r   <= 2'd0;
            latch_strobe_o <= 1'b0;
        end
        else
        begin
            strobe_div_r <= strobe_div_r + 2'd1;
            if (mode_r == PM_STOP)
                latch_strobe_o <= 1'b0;
            else if (strobe_off_r && !ext_data_move_i)
                latch_strobe_o <= 1'b1;  // [R13]
            else
                latch_strobe_o <= (strobe_div_r == 2'd0);  // [R14]
        end
    end

    // per timer rate dividers
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_rate
            pmsc_rate_div u_div
            (
                .clk_i     (clk_i),
                .reset_n_i (reset_n_i),
                .run_i     (mode_r != PM_STOP),
                .fast_i    (rate_fast_r[gi]),
                .tick_o    (tick_w[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            timer_tick_o <= 3'b000;
        else
            timer_tick_o <= tick_w;  // [R15] [R16]
    end

    // register read
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_o <= `PMSC_RESET_BYTE;
        else if (rd_i)
        begin
            case (addr_i)
                `PMSC_ADDR_POWER_CONTROL: rdata_o <= {6'h00, stop_req_r, idle_req_r};
                `PMSC_ADDR_CLOCK_RATE:    rdata_o <= {2'b00, rate_fast_r, 3'b000};
                `PMSC_ADDR_EXT_FLAG:      rdata_o <= {5'h00, mode_r == PM_RING,
                                                      ring_sel_r, bandgap_keep_r};  // [R11]
                `PMSC_ADDR_POWER_MGMT:    rdata_o <= {5'h00, strobe_off_r, 2'b00};
                `PMSC_ADDR_SUPERVISOR:    rdata_o <= {2'b00, pf_en_r, pf_flag_r, 4'h0};
                default:                  rdata_o <= `PMSC_RESET_BYTE;
            endcase
        end
    end

    // checks
    sequence s_ring_wake;
        mode_r == PM_STOP && stop_exit && ring_sel_r && !core_reset_o;
    endsequence

    a_ring_wake_clk: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_ring_wake |=> mode_r == PM_RING)  // [R09]
        else $error("ring wake not taken");
    a_ring_status: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ring_en_o == (mode_r == PM_RING))  // [R11]
        else $error("ring status mismatch");
    a_ring_return: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wake_cnt_r <= `PMSC_WAKE_COUNT - 17'h1)  // [R10]
        else $error("ring period too long");
    a_stop_gates: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mode_r == PM_STOP |-> !crystal_en_o && !cpu_clk_en_o)  // [R04]
        else $error("clock running in stop");
    a_stop_wake_src: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mode_r == PM_STOP && !stop_exit && !core_reset_o |=> mode_r == PM_STOP)  // [R05]
        else $error("stop left without cause");
    a_bandgap_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mode_r == PM_STOP |-> bandgap_en_o == bandgap_keep_r)  // [R06]
        else $error("bandgap state wrong in stop");
    a_bandgap_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mode_r != PM_STOP && $past(mode_r) != PM_STOP |-> bandgap_en_o)  // [R08]
        else $error("bandgap off outside stop");
    a_pf_flag_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pf_flag_r && !hit(addr_i, `PMSC_ADDR_SUPERVISOR) |=> pf_flag_r)  // [R21]
        else $error("warning flag lost");
    a_reset_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        below_reset_threshold_i |=> core_reset_o)  // [R18]
        else $error("reset not held");
    a_idle_exit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mode_r == PM_IDLE && irq_enabled_i |=> mode_r == PM_RUN)  // [R02]
        else $error("idle not left");
    a_key_window: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        win_cnt_r == 2'd0 && !core_reset_o |=> bandgap_keep_r == $past(bandgap_keep_r))  // [R22]
        else $error("protected write outside window");
endmodule

// [bench/pmsc_supply_model.sv]
// bench supply monitor: turns a commanded supply level into threshold flags
// assumes the level changes on the falling clock edge
`timescale 1ns/10ps
module pmsc_supply_model
(
    // clock
    input  wire logic       clk_i,
    // commanded level: 0 good, 1 warning, 2 below reset
    input  wire logic [1:0] level_i,
    // monitor flags
    output logic            below_reset_threshold_o,
    output logic            below_warning_threshold_o
);
    // reset threshold lies under the warning threshold
    always_ff @(posedge clk_i)
    begin
        below_reset_threshold_o   <= (level_i == 2'h2);
        below_warning_threshold_o <= (level_i != 2'h0);
    end
endmodule

// [bench/tb_pmsc_power_ctrl.sv]
// self-checking bench for power mode and supply control
// assumes the supply model is compiled before this file
`timescale 1ns/10ps
module tb_pmsc_power_ctrl;
    logic        clk_i, reset_n_i, wr_i, rd_i;
    logic [7:0]  addr_i, wdata_i, rdata_o;
    logic        irq_enabled_i, ext_irq_i, ext_data_move_i;
    logic [1:0]  level;
    logic        brst, bwarn;
    logic        cpu_clk_en_o, periph_clk_en_o, crystal_en_o, ring_en_o;
    logic        bandgap_en_o, latch_strobe_o, core_reset_o, pf_irq_o;
    logic [2:0]  timer_tick_o;
    logic [15:0] pf_vector_o;
    logic [7:0]  am [6] = '{8'h87, 8'h8e, 8'h91, 8'hd8, 8'hc4, 8'h10};
    // warning flag is set by the low supply seen while reset is held
    logic [7:0]  ae [6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
    int          miscompares;
    int          compares;
    int          p;
    int          n;

    pmsc_supply_model u_sup
    (
        .clk_i                     (clk_i),
        .level_i                   (level),
        .below_reset_threshold_o   (brst),
        .below_warning_threshold_o (bwarn)
    );

    pmsc_power_ctrl u_dut
    (
        .clk_i                     (clk_i),
        .reset_n_i                 (reset_n_i),
        .wr_i                      (wr_i),
        .rd_i                      (rd_i),
        .addr_i                    (addr_i),
        .wdata_i                   (wdata_i),
        .rdata_o                   (rdata_o),
        .irq_enabled_i             (irq_enabled_i),
        .ext_irq_i                 (ext_irq_i),
        .below_reset_threshold_i   (brst),
        .below_warning_threshold_i (bwarn),
        .ext_data_move_i           (ext_data_move_i),
        .cpu_clk_en_o              (cpu_clk_en_o),
        .periph_clk_en_o           (periph_clk_en_o),
        .crystal_en_o              (crystal_en_o),
        .ring_en_o                 (ring_en_o),
        .bandgap_en_o              (bandgap_en_o),
        .latch_strobe_o            (latch_strobe_o),
        .timer_tick_o              (timer_tick_o),
        .core_reset_o              (core_reset_o),
        .pf_irq_o                  (pf_irq_o),
        .pf_vector_o               (pf_vector_o)
    );

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // write strobe stays up so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        rd_i = 1'b0;
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
    endtask

    task automatic cyc(input int k);
        @(negedge clk_i);
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (k) @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        wr_i = 1'b0;
        rd_i = 1'b1;
        addr_i = a;
        cyc(1);
        chk($sformatf("rdata %h", a), {24'h0, e}, {24'h0, rdata_o});
    endtask

    task automatic keys();
        wr(8'hc7, 8'haa);
        wr(8'hc7, 8'h55);
    endtask

    function automatic logic sig(input int s);
        return (s == 3) ? latch_strobe_o : timer_tick_o[s];
    endfunction

    // cycles from one high sample to the next; 1 means held high
    task automatic per(input int s, input int e);
        int i;
        int q;
        i = 0;
        q = 0;
        cyc(0);
        while (sig(s) !== 1'b1 && i < 40)
        begin
            @(negedge clk_i);
            i++;
        end
        do
        begin
            @(negedge clk_i);
            q++;
        end
        while (sig(s) !== 1'b1 && q < 40);
        chk($sformatf("period %0d", s), e, q);
    endtask

    task automatic mode(input logic c, input logic pc, input logic x, input logic b);
        chk("cpu_clk_en", c, cpu_clk_en_o);
        chk("periph_clk_en", pc, periph_clk_en_o);
        chk("crystal_en", x, crystal_en_o);
        chk("bandgap_en", b, bandgap_en_o);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial
    begin
        #10000000;
        miscompares++;
        stop_test();
    end

    initial
    begin
        reset_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        irq_enabled_i = 1'b0;
        ext_irq_i = 1'b0;
        ext_data_move_i = 1'b0;
        level = 2'h2;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        reset_n_i = 1'b1;
        cyc(100);
        chk("core_reset", 1, core_reset_o);
        level = 2'h0;
        n = 0;
        while (core_reset_o === 1'b1 && n < 70000)
        begin
            @(negedge clk_i);
            n++;
        end
        chk("reset_count", 1, n >= 65536 && n <= 65539);
        foreach (am[i])
            rd(am[i], ae[i]);
        // timer rates, one bit at a time
        for (int k = 0; k < 3; k++)
        begin
            per(k, 12);
            wr(8'h8e, 8'h08 << k);
            per(k, 4);
            per((k + 1) % 3, 12);
            wr(8'h8e, 8'h00);
        end
        // address latch strobe
        per(3, 4);
        wr(8'hc4, 8'h04);
        per(3, 1);
        chk("latch_strobe", 1, latch_strobe_o);
        ext_data_move_i = 1'b1;
        per(3, 4);
        ext_data_move_i = 1'b0;
        wr(8'hc4, 8'h00);
        // protected bandgap bit, then stop with reference kept
        wr(8'h91, 8'h01);
        rd(8'h91, 8'h00);
        keys();
        wr(8'h91, 8'h01);
        rd(8'h91, 8'h01);
        wr(8'hd8, 8'h20);
        wr(8'h87, 8'h02);
        cyc(3);
        mode(0, 0, 0, 1);
        irq_enabled_i = 1'b1;
        cyc(4);
        chk("cpu_clk_en", 0, cpu_clk_en_o);
        irq_enabled_i = 1'b0;
        level = 2'h1;
        cyc(4);
        mode(1, 1, 1, 1);
        chk("pf_irq", 1, pf_irq_o);
        chk("pf_vector", 32'h33, pf_vector_o);
        rd(8'h87, 8'h00);
        rd(8'hd8, 8'h30);
        level = 2'h0;
        wr(8'hd8, 8'h20);
        rd(8'hd8, 8'h20);
        chk("pf_irq", 0, pf_irq_o);
        // flag is set with the interrupt disabled
        wr(8'hd8, 8'h00);
        level = 2'h1;
        cyc(4);
        chk("pf_irq", 0, pf_irq_o);
        rd(8'hd8, 8'h10);
        level = 2'h0;
        wr(8'hd8, 8'h00);
        rd(8'hd8, 8'h00);
        // stop without reference, crystal wake
        keys();
        wr(8'h91, 8'h00);
        wr(8'h87, 8'h02);
        cyc(3);
        mode(0, 0, 0, 0);
        ext_irq_i = 1'b1;
        cyc(3);
        ext_irq_i = 1'b0;
        mode(1, 1, 1, 1);
        chk("ring_en", 0, ring_en_o);
        rd(8'h87, 8'h00);
        // idle
        wr(8'h87, 8'h01);
        cyc(2);
        mode(0, 1, 1, 1);
        rd(8'h87, 8'h01);
        irq_enabled_i = 1'b1;
        cyc(3);
        irq_enabled_i = 1'b0;
        chk("cpu_clk_en", 1, cpu_clk_en_o);
        rd(8'h87, 8'h00);
        // ring wake
        wr(8'h91, 8'h02);
        wr(8'h87, 8'h02);
        cyc(3);
        ext_irq_i = 1'b1;
        cyc(3);
        ext_irq_i = 1'b0;
        chk("ring_en", 1, ring_en_o);
        chk("cpu_clk_en", 1, cpu_clk_en_o);
        rd(8'h91, 8'h06);
        // brownout
        level = 2'h2;
        cyc(3);
        chk("core_reset", 1, core_reset_o);
        stop_test();
    end
endmodule
